// ### verilog/serial_pcs_pkg.sv
// Constants, carriers and helpers for the serial port coding sublayer control block
package serial_pcs_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned CODE_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [21:0] DIG_CTRL_IDX = 22'h1f8000;
  localparam logic [21:0] AN_CTRL_IDX = 22'h1f8001;
  localparam logic [21:0] AN_STAT_IDX = 22'h1f8002;
  localparam logic [21:0] AN_ADV_IDX = 22'h1f0004;

  // Digital control fields
  localparam int unsigned DC_LOOP_BIT = 14;
  localparam int unsigned DC_PSAVE_BIT = 11;
  localparam logic [15:0] DIG_CTRL_RST = 16'h2400;

  // Auto-negotiation control fields
  localparam int unsigned AC_LINK_BIT = 4;
  localparam int unsigned AC_MASTER_BIT = 3;
  localparam int unsigned AC_VAR_LSB = 1;
  localparam int unsigned AC_IRQEN_BIT = 0;
  localparam logic [15:0] AN_CTRL_RST = 16'h0004;
  localparam logic [15:0] AN_CTRL_MASK = 16'h001f;

  // Auto-negotiation status fields
  localparam int unsigned AS_LINK_BIT = 4;
  localparam int unsigned AS_SPEED_LSB = 2;
  localparam int unsigned AS_DUPLEX_BIT = 1;
  localparam int unsigned AS_DONE_BIT = 0;

  // Advertisement register: pause, half and full duplex are writable
  localparam logic [15:0] AN_ADV_RST = 16'h0020;
  localparam logic [15:0] AN_ADV_MASK = 16'h01e0;

  // Coding sublayer variants
  localparam logic [1:0] VAR_SERDES = 2'h0;
  localparam logic [1:0] VAR_SGMII = 2'h2;

  // Partner speed codes
  localparam logic [1:0] SPEED_10 = 2'h0;
  localparam logic [1:0] SPEED_100 = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Auto-negotiation configuration in force
  typedef struct packed {
    logic link_cfg;
    logic tx_master;
    logic [1:0] coding_sublayer_variant;
    logic irq_en;
  } an_cfg_s;

  // Result word from the negotiation engine
  typedef struct packed {
    logic link;
    logic [1:0] speed;
    logic duplex;
  } partner_s;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [21:0] idx);
    return {idx, 2'b00};
  endfunction

  // Unpack the writable control bits into the configuration carrier
  function automatic an_cfg_s cfg_of(input logic [15:0] w);
    an_cfg_s c;
    c.link_cfg = w[AC_LINK_BIT];
    c.tx_master = w[AC_MASTER_BIT];
    c.coding_sublayer_variant = w[AC_VAR_LSB +: 2];
    c.irq_en = w[AC_IRQEN_BIT];
    return c;
  endfunction

endpackage

// ### verilog/code_loop.sv
// Code-group path between deserializer, encoder and serializer with loopback and power save
module code_loop
  import serial_pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic loop_en,
  input wire logic psave,
  input wire logic [CODE_W-1:0] rx_code,
  input wire logic [CODE_W-1:0] enc_code,
  output logic [CODE_W-1:0] tx_code,
  output logic rx_enable,
  output logic tx_enable,
  output logic pll_enable
);

  logic [CODE_W-1:0] tx_code_q;
  logic rx_en_q;
  logic tx_en_q;

  // Select looped receive data or encoder output, silent in power save
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_code_q <= '0;
    end else if (psave) begin
      tx_code_q <= '0;
    end else if (loop_en) begin
      tx_code_q <= rx_code;
    end else begin
      tx_code_q <= enc_code;
    end
  end

  // Receiver and transmitter enables drop in power save
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_en_q <= 1'b1;
      tx_en_q <= 1'b1;
    end else begin
      rx_en_q <= !psave;
      tx_en_q <= !psave;
    end
  end

  assign tx_code = tx_code_q;
  assign rx_enable = rx_en_q;
  assign tx_enable = tx_en_q;
  assign pll_enable = 1'b1; // PLL kept running in every mode

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_loop_path: assert property (!rst && loop_en && !psave |=> tx_code == $past(rx_code))
    else $error("loopback output differs from received code");
  chk_normal_path: assert property (!rst && !loop_en && !psave |=> tx_code == $past(enc_code))
    else $error("normal output differs from encoder code");
  chk_power_save: assert property (psave |=> !rx_enable && !tx_enable && pll_enable && tx_code == '0)
    else $error("power save did not stop receiver and transmitter");

endmodule

// ### verilog/serial_pcs_regs.sv
// APB register bank controlling the serial port coding sublayer, loopback and power save
//
// Behaviour
// - Loopback bit returns received data to transmitter
// - Loopback done digitally in the coding sublayer
// - Power save stops receiver and transmitter, PLL on
// - Control changes apply at next advertisement write
// - Role bit selects MAC side or PHY side in SGMII only; other variants are MAC side
// - Variant field: 00 SerDes, 10 SGMII, reset 10
// - Enable bit gates the negotiation-complete interrupt
// - Complete flag sticky, cleared by writing zero
// - SGMII partner speed reported as two-bit code
//
// The APB slave port is this design's own decision.
module serial_pcs_regs
  import serial_pcs_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic AN_DONE,
  input wire partner_s PARTNER,
  input wire logic [CODE_W-1:0] RX_CODE,
  input wire logic [CODE_W-1:0] ENC_CODE,
  output logic [CODE_W-1:0] TX_CODE,
  output logic RX_ENABLE,
  output logic TX_ENABLE,
  output logic PLL_ENABLE,
  output an_cfg_s AN_CFG,
  output logic SERDES_AN,
  output logic SGMII_AN,
  output logic PHY_SIDE_ROLE,
  output logic IRQ
);

  // Register state
  logic [15:0] dig_ctrl_q;
  logic [15:0] an_stage_q;
  logic [15:0] an_adv_q;
  an_cfg_s an_eff_q;
  logic serdes_an_q;
  logic sgmii_an_q;
  logic phy_role_q;
  logic done_q;
  logic done_d;
  partner_s result_q;
  logic [DATA_W-1:0] prdata_q;
  logic err_q;

  // Bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_dig;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_adv;
  logic hit_any;
  logic wr_dig;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_adv;
  logic [15:0] wdata16;
  logic [15:0] stat_word;
  an_cfg_s stage_cfg;

  // APB phases and address match
  assign setup_ph = PSEL && !PENABLE;
  assign access_ph = PSEL && PENABLE;
  assign wr_en = access_ph && PWRITE;
  assign hit_dig = (PADDR == byte_addr(DIG_CTRL_IDX));
  assign hit_ctrl = (PADDR == byte_addr(AN_CTRL_IDX));
  assign hit_stat = (PADDR == byte_addr(AN_STAT_IDX));
  assign hit_adv = (PADDR == byte_addr(AN_ADV_IDX));
  assign hit_any = hit_dig || hit_ctrl || hit_stat || hit_adv;
  assign wdata16 = PWDATA[15:0];

  // Write strobes, one per register, on the completing access edge
  assign wr_dig = wr_en && hit_dig;
  assign wr_ctrl = wr_en && hit_ctrl;
  assign wr_stat = wr_en && hit_stat;
  assign wr_adv = wr_en && hit_adv;

  // Staged control value as a carrier
  assign stage_cfg = cfg_of(an_stage_q);

  // Status word as software sees it
  always_comb begin
    stat_word = '0;
    stat_word[AS_LINK_BIT] = result_q.link;
    stat_word[AS_SPEED_LSB +: 2] = result_q.speed;
    stat_word[AS_DUPLEX_BIT] = result_q.duplex;
    stat_word[AS_DONE_BIT] = done_q;
  end

  // Zero wait states; error answer for an unmapped address
  assign PREADY = access_ph;
  assign PSLVERR = access_ph && err_q;
  assign PRDATA = prdata_q;

  // Read data and error captured in the setup cycle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup_ph) begin
      err_q <= !hit_any;
      if (PWRITE) begin
        prdata_q <= '0;
      end else if (hit_dig) begin
        prdata_q <= {16'h0000, dig_ctrl_q};
      end else if (hit_ctrl) begin
        prdata_q <= {16'h0000, an_stage_q};
      end else if (hit_stat) begin
        prdata_q <= {16'h0000, stat_word};
      end else if (hit_adv) begin
        prdata_q <= {16'h0000, an_adv_q};
      end else begin
        prdata_q <= '0;
      end
    end
  end

  // Digital control: every bit stored, reserved ones included
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dig_ctrl_q <= DIG_CTRL_RST;
    end else if (wr_dig) begin
      dig_ctrl_q <= wdata16;
    end
  end

  // Control writes are only staged here
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      an_stage_q <= AN_CTRL_RST;
    end else if (wr_ctrl) begin
      an_stage_q <= wdata16 & AN_CTRL_MASK;
    end
  end

  // Advertisement register, writable ability bits only
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      an_adv_q <= AN_ADV_RST;
    end else if (wr_adv) begin
      an_adv_q <= wdata16 & AN_ADV_MASK;
    end
  end

  // Staged control comes into force on an advertisement write
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      an_eff_q <= cfg_of(AN_CTRL_RST);
    end else if (wr_adv) begin
      an_eff_q <= stage_cfg;
    end
  end

  // Variant and role decode, taken at the same commit edge
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      serdes_an_q <= (AN_CTRL_RST[AC_VAR_LSB +: 2] == VAR_SERDES);
      sgmii_an_q <= (AN_CTRL_RST[AC_VAR_LSB +: 2] == VAR_SGMII);
      phy_role_q <= 1'b0;
    end else if (wr_adv) begin
      serdes_an_q <= (stage_cfg.coding_sublayer_variant == VAR_SERDES);
      sgmii_an_q <= (stage_cfg.coding_sublayer_variant == VAR_SGMII);
      phy_role_q <= (stage_cfg.coding_sublayer_variant == VAR_SGMII) && stage_cfg.tx_master;
    end
  end

  // Completion flag: set wins over a clearing write of zero
  always_comb begin
    done_d = done_q;
    if (wr_stat && !wdata16[AS_DONE_BIT]) begin
      done_d = 1'b0;
    end
    if (AN_DONE) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // Partner result captured at completion in SGMII mode
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      result_q <= '0;
    end else if (AN_DONE && sgmii_an_q) begin
      result_q <= PARTNER;
    end
  end

  // Level interrupt from flag and enable in force
  assign IRQ = done_q && an_eff_q.irq_en;

  // Configuration outputs
  assign AN_CFG = an_eff_q; // Link and role bits as programmed
  assign SERDES_AN = serdes_an_q;
  assign SGMII_AN = sgmii_an_q;
  assign PHY_SIDE_ROLE = phy_role_q;

  // Code-group path with loopback and power save
  code_loop u_code_loop (
    .clk(SYS_CLK),
    .rst(RST),
    .loop_en(dig_ctrl_q[DC_LOOP_BIT]),
    .psave(dig_ctrl_q[DC_PSAVE_BIT]),
    .rx_code(RX_CODE),
    .enc_code(ENC_CODE),
    .tx_code(TX_CODE),
    .rx_enable(RX_ENABLE),
    .tx_enable(TX_ENABLE),
    .pll_enable(PLL_ENABLE)
  );

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence s_ctrl_write;
    PSEL && PENABLE && PWRITE && PADDR == byte_addr(AN_CTRL_IDX);
  endsequence

  sequence s_adv_write;
    PSEL && PENABLE && PWRITE && PADDR == byte_addr(AN_ADV_IDX);
  endsequence

  sequence s_stat_clear;
    PSEL && PENABLE && PWRITE && PADDR == byte_addr(AN_STAT_IDX) && !PWDATA[AS_DONE_BIT] && !AN_DONE;
  endsequence

  chk_cfg_hold: assert property (s_ctrl_write |=> an_eff_q == $past(an_eff_q))
    else $error("control write took effect without advertisement write");
  chk_cfg_commit: assert property (s_adv_write |=> an_eff_q == cfg_of(an_stage_q))
    else $error("advertisement write did not commit staged control");
  chk_role_select: assert property (s_adv_write |=>
      PHY_SIDE_ROLE == (an_eff_q.coding_sublayer_variant == VAR_SGMII && an_eff_q.tx_master))
    else $error("port role does not follow role bit");
  chk_variant_decode: assert property (s_adv_write |=>
      SERDES_AN == (an_eff_q.coding_sublayer_variant == VAR_SERDES) &&
      SGMII_AN == (an_eff_q.coding_sublayer_variant == VAR_SGMII))
    else $error("variant decode wrong");
  chk_done_sticky: assert property (AN_DONE |=> done_q [*2] or (done_q ##1 !done_q))
    else $error("completion flag not set");
  chk_done_clear: assert property (done_q && !(wr_stat && !wdata16[AS_DONE_BIT]) && !AN_DONE |=> done_q)
    else $error("completion flag lost without a clearing write");
  chk_clear_zero: assert property (s_stat_clear |=> !done_q)
    else $error("writing zero did not clear completion flag");
  chk_irq_level: assert property (AN_DONE && an_eff_q.irq_en && !wr_adv |=> IRQ)
    else $error("interrupt missing after completion");
  chk_irq_gated: assert property (!an_eff_q.irq_en |-> !IRQ)
    else $error("interrupt raised while disabled");
  chk_speed_code: assert property (AN_DONE && sgmii_an_q |=> stat_word[AS_SPEED_LSB +: 2] == $past(PARTNER.speed))
    else $error("partner speed not reported");
  chk_bus_ready: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> PREADY) // Zero wait answer
    else $error("ready not given in access phase");

  // Bus answer only in the access phase, error only for an unmapped address
  chk_ready_idle: assert property (!(PSEL && PENABLE) |-> // Zero wait answer
      !PREADY && !PSLVERR)
    else $error("ready or error outside an access phase");
  chk_err_unmapped: assert property (PSEL && !PENABLE ##1 PSEL && PENABLE |-> // Address decode
      PSLVERR == !$past(hit_any))
    else $error("slave error does not match address decode");

  // Read data taken in the setup cycle, upper half always zero
  chk_rdata_upper: assert property (PSEL && PENABLE |-> PRDATA[31:16] == 16'h0000) // One register per word
    else $error("read data upper half not zero");
  chk_rdata_dig: assert property (setup_ph && !PWRITE && hit_dig |=>
      PRDATA == {16'h0000, $past(dig_ctrl_q)})
    else $error("digital control read data wrong");
  chk_rdata_ctrl: assert property (setup_ph && !PWRITE && hit_ctrl |=>
      PRDATA == {16'h0000, $past(an_stage_q)})
    else $error("control read data wrong");
  chk_rdata_stat: assert property (setup_ph && !PWRITE && hit_stat |=>
      PRDATA[15:0] == $past(stat_word))
    else $error("status read data wrong");
  chk_rdata_adv: assert property (setup_ph && !PWRITE && hit_adv |=> // Advertisement
      PRDATA == {16'h0000, $past(an_adv_q)})
    else $error("advertisement read data wrong");
  chk_rdata_write: assert property (setup_ph && PWRITE |=> PRDATA == '0) // Write answer
    else $error("read data not zero in a write");
  chk_rdata_unmapped: assert property (setup_ph && !hit_any |=> PRDATA == '0) // Address decode
    else $error("read data not zero for an unmapped address");

  // Each register changes only on its own write strobe; configuration in force and decodes only on the advertisement one
  chk_dig_write: assert property (wr_dig |=> dig_ctrl_q == $past(wdata16))
    else $error("digital control write lost");
  chk_dig_hold: assert property (!wr_dig |=> $stable(dig_ctrl_q))
    else $error("digital control changed without a write");
  chk_stage_write: assert property (wr_ctrl |=>
      an_stage_q == ($past(wdata16) & AN_CTRL_MASK))
    else $error("control write not staged");
  chk_stage_hold: assert property (!wr_ctrl |=> $stable(an_stage_q))
    else $error("staged control changed without a write");
  chk_adv_write: assert property (wr_adv |=> // Advertisement
      an_adv_q == ($past(wdata16) & AN_ADV_MASK))
    else $error("advertisement write lost");
  chk_adv_hold: assert property (!wr_adv |=> $stable(an_adv_q)) // Advertisement
    else $error("advertisement changed without a write");
  chk_eff_hold: assert property (!wr_adv |=> $stable(an_eff_q))
    else $error("configuration in force changed without commit");
  chk_decode_hold: assert property (!wr_adv |=>
      $stable(SERDES_AN) && $stable(SGMII_AN) && $stable(PHY_SIDE_ROLE))
    else $error("variant or role decode changed without commit");

  // Decodes: one variant at most, PHY side only in SGMII
  chk_variant_excl: assert property (!(SERDES_AN && SGMII_AN))
    else $error("both variants flagged");
  chk_role_sgmii: assert property (PHY_SIDE_ROLE |-> SGMII_AN)
    else $error("PHY side role outside SGMII");

  // Completion flag set only by the engine, result kept between completions
  chk_done_rise: assert property ($rose(done_q) |-> $past(AN_DONE))
    else $error("completion flag set without completion");
  chk_set_wins: assert property (wr_stat && !wdata16[AS_DONE_BIT] && AN_DONE |=> done_q)
    else $error("clear won over completion");
  chk_irq_clear: assert property (wr_stat && !wdata16[AS_DONE_BIT] && !AN_DONE |=> !IRQ)
    else $error("interrupt stayed after clearing write");
  chk_result_hold: assert property (!AN_DONE |=> $stable(result_q))
    else $error("partner result changed without completion");
  chk_result_mode: assert property (AN_DONE && !sgmii_an_q |=> $stable(result_q))
    else $error("partner result captured outside SGMII");

endmodule

// ### sim/an_partner.sv
// Negotiation engine and code group source facing the control block
module an_partner
  import serial_pcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire partner_s result,
  output logic an_done,
  output partner_s partner,
  output logic [CODE_W-1:0] rx_code,
  output logic [CODE_W-1:0] enc_code
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle completion pulse; result valid only beside it, inverted after
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      an_done <= 1'b0;
      partner <= '0;
    end else begin
      an_done <= go;
      partner <= go ? result : partner_s'(~partner);
    end
  end
  // Code groups change every cycle so a stuck path shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_code <= 10'h155;
      enc_code <= 10'h0aa;
    end else begin
      rx_code <= rx_code + 10'h0d3;
      enc_code <= {enc_code[8:0], ~enc_code[9]};
    end
  end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the coding sublayer control registers
module testbench import serial_pcs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] d; logic rd; logic err;} note_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, an_done, rx_en, tx_en, pll_en, serdes, sgmii, phy_role, irq;
  logic [CODE_W-1:0] rx_code, enc_code, tx_code, prx, penc;
  logic [15:0] w;
  logic [15:0] st;
  logic [15:0] dcs [5] = '{16'h6400, 16'h2400, 16'h2c00, 16'h6c00, 16'h2400};
  partner_s result = '0;
  partner_s partner;
  an_cfg_s cfg;
  note_s notes[$];
  note_s seen;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  serial_pcs_regs dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .AN_DONE(an_done), .PARTNER(partner), .RX_CODE(rx_code), .ENC_CODE(enc_code), .TX_CODE(tx_code),
    .RX_ENABLE(rx_en), .TX_ENABLE(tx_en), .PLL_ENABLE(pll_en), .AN_CFG(cfg), .SERDES_AN(serdes),
    .SGMII_AN(sgmii), .PHY_SIDE_ROLE(phy_role), .IRQ(irq));
  an_partner peer (.clk(clk), .rst(rst), .go(go), .result(result), .an_done(an_done),
    .partner(partner), .rx_code(rx_code), .enc_code(enc_code));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One APB transfer; the expected answer is queued for the watcher
  task automatic apb(input logic wr, input logic [21:0] idx, input logic [15:0] wd, input logic [15:0] exp,
                     input logic err);
    notes.push_back('{exp, !wr, err});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= byte_addr(idx);
    pwdata <= {16'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse the negotiation engine and let the flag settle
  task automatic negotiate();
    @(posedge clk);
    result <= '{1'b1, 2'($urandom % 3), 1'($urandom)};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Compare every completed bus answer with the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      seen = notes.pop_front();
      if (seen.rd) chk("read data", {16'h0, seen.d}, prdata);
      chk("slave error", {31'h0, seen.err}, {31'h0, pslverr});
    end
  end

  // Registered code path follows the values sampled one edge earlier
  always @(posedge clk) begin
    prx <= rx_code;
    penc <= enc_code;
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(84));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, DIG_CTRL_IDX, 0, 16'h2400, 0);
    apb(0, AN_CTRL_IDX, 0, 16'h0004, 0);
    apb(0, AN_STAT_IDX, 0, 16'h0000, 0);
    chk("cfg at reset", 32'h04, {27'h0, cfg});
    chk("sgmii decode", 32'h1, {31'h0, sgmii});
    $display("test reset values done");
    // Link and role bits set as software must for SerDes
    for (int v = 0; v < 4; v++) begin
      w = {11'h0, 2'b11, 2'(v), 1'b0};
      apb(1, AN_CTRL_IDX, w, 0, 0);
      apb(0, AN_CTRL_IDX, 0, w, 0);
      chk("cfg before commit", (v == 0) ? 32'h04 : {27'h0, 5'(w) - 5'h2}, {27'h0, cfg});
      apb(1, AN_ADV_IDX, 16'h0020, 0, 0);
      #1;
      chk("cfg after commit", {27'h0, w[4:0]}, {27'h0, cfg});
      chk("serdes decode", {31'h0, v == 0}, {31'h0, serdes});
      chk("sgmii decode", {31'h0, v == 2}, {31'h0, sgmii});
      chk("phy role", {31'h0, v == 2}, {31'h0, phy_role});
    end
    $display("test variants done");
    // MAC side facing a PHY-side partner
    apb(1, AN_CTRL_IDX, 16'h0005, 0, 0);
    apb(1, AN_ADV_IDX, 16'h0020, 0, 0);
    #1;
    chk("mac role", 32'h0, {31'h0, phy_role});
    negotiate();
    st = {11'h0, result, 1'b1};
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(0, AN_STAT_IDX, 0, st, 0);
    apb(1, AN_STAT_IDX, 16'h0001, 0, 0);
    apb(0, AN_STAT_IDX, 0, st, 0);
    apb(1, AN_STAT_IDX, 16'h0000, 0, 0);
    apb(0, AN_STAT_IDX, 0, st & 16'hfffe, 0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1, AN_CTRL_IDX, 16'h0004, 0, 0);
    negotiate();
    chk("irq before commit", 32'h1, {31'h0, irq});
    apb(1, AN_ADV_IDX, 16'h0020, 0, 0);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(0, AN_STAT_IDX, 0, {11'h0, result, 1'b1}, 0);
    // SerDes completion leaves the partner result untouched
    st = {11'h0, result, 1'b1};
    apb(1, AN_STAT_IDX, 16'h0000, 0, 0);
    apb(1, AN_CTRL_IDX, 16'h0018, 0, 0);
    apb(1, AN_ADV_IDX, 16'h0020, 0, 0);
    negotiate();
    chk("serdes decode", 32'h1, {31'h0, serdes});
    apb(0, AN_STAT_IDX, 0, st, 0);
    $display("test interrupt done");
    foreach (dcs[i]) begin
      apb(1, DIG_CTRL_IDX, dcs[i], 0, 0);
      apb(0, DIG_CTRL_IDX, 0, dcs[i], 0);
      repeat (3) begin
        @(posedge clk);
        #1;
        chk("tx code", dcs[i][11] ? 32'h0 : {22'h0, dcs[i][14] ? prx : penc}, {22'h0, tx_code});
        chk("rx enable", {31'h0, !dcs[i][11]}, {31'h0, rx_en});
        chk("tx enable", {31'h0, !dcs[i][11]}, {31'h0, tx_en});
        chk("pll enable", 32'h1, {31'h0, pll_en});
      end
    end
    $display("test code path done");
    apb(1, 22'h000123, 16'hffff, 0, 1);
    apb(0, 22'h000123, 0, 16'h0000, 1);
    apb(0, DIG_CTRL_IDX, 0, 16'h2400, 0);
    $display("test unmapped done");
    repeat (2) @(posedge clk);
    chk("pending answers", 32'h0, notes.size());
    finish_test();
  end
endmodule
